//--- rtl/rsf_consts.vh
/*
 * constants for the receive status flag block: register offsets, bit
 * positions, reset values. assumes a 32-bit avalon-mm word bus.
 */
`ifndef RSF_CONSTS_VH
`define RSF_CONSTS_VH

`define RSF_ADDR_W          8
`define RSF_OFS_STATUS      8'h80
`define RSF_OFS_IRQ_ENABLE  8'h7C
`define RSF_DATA_W          32
`define RSF_FLAG_W          8
`define RSF_SLOT_W          10

`define RSF_BIT_OVERRUN     0
`define RSF_BIT_EARLY_SYNC  1
`define RSF_BIT_CLK_FAULT   2
`define RSF_BIT_SLOT_PAR    3
`define RSF_BIT_FINAL_SLOT  4
`define RSF_BIT_DATA_READY  5
`define RSF_BIT_FRAME_START 6
`define RSF_BIT_DMA_OVERRD  7
`define RSF_BIT_ERR_SUM     8
`define RSF_IEN_FRAME_START 7
`define RSF_IEN_DMA_OVERRD  3

`define RSF_FLAGS_RESET     8'h00
`define RSF_IEN_RESET       8'h00
`define RSF_IEN_MASK        8'hBF
`define RSF_FLAG_MASK       8'hF7
`define RSF_ZERO32          32'h00000000

`endif

//--- rtl/rsf_sync3.v
/*
 * three-flop input synchroniser with agreement filter for one level.
 * assumes the input is asynchronous to clk; output changes once the
 * second and third stages agree.
 */
`timescale 1ns/10ps
module rsf_sync3 (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // level in and filtered level out
    input  wire din,
    output wire dout
);

    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg out_q;

    // first stage is read only by the second stage
    always @(posedge clk)
    begin
        if (rst)
        begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                out_q <= s3_q; // agreement filters a one-stage glitch
        end
    end

    assign dout = out_q;

endmodule

//--- rtl/rsf_rx_status.v
/*
 * receive status register with sticky event flags, write-one-to-clear,
 * error summary, slot parity, irq enable register and avalon-mm slave.
 * assumes event inputs are single-cycle pulses from logic on clk, and
 * that the clock fault report arrives as an asynchronous level.
 */
// Design decision made here: the Avalon-MM slave port.
// How it works
// - a hardware set beats a software clear landing in the same cycle
// - such a collision raises a fresh receive interrupt request pulse
// - bit 8 reads as or of overrun, early sync, clock fault, dma flags
// - dma overread flag sets when reads per slot exceed configured receivers
// - flags clear only by writing one; writing zero leaves them
// - interrupt high while any flag is set with its enable bit
// - frame start flag sets on a new receive frame sync
// - data ready flag sets when a word moves into the receive buffer
// - every data ready set also pulses the dma request
// - final slot flag sets with data ready on a frame's last slot
// - bit 3 mirrors slot counter lsb, one meaning odd slot
// - bits 31 to 9 read zero and ignore writes
// - clock fault flag sets when the clock check reports an error
// - early sync flag sets when frame sync arrives too early
// - overrun flag sets when buffer is refilled before it was read
`timescale 1ns/10ps
`include "rsf_consts.vh"
module rsf_rx_status #(
    parameter SLOT_W = `RSF_SLOT_W,
    parameter SER_W  = 4
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst,
    // avalon-mm slave
    input  wire [`RSF_ADDR_W-1:0]  avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [`RSF_DATA_W-1:0]  avs_writedata,
    input  wire [3:0]              avs_byteenable,
    output wire [`RSF_DATA_W-1:0]  avs_readdata,
    output wire                    avs_waitrequest,
    // receive datapath events, one-cycle pulses on clk, with last slot, receiver count and slot counter as levels
    input  wire                    rx_frame_sync,
    input  wire                    rx_sync_early,
    input  wire                    rx_word_moved,
    input  wire                    rx_buffer_read,
    input  wire                    rx_is_last_slot,
    input  wire                    rx_slot_start,
    input  wire [SER_W-1:0]        rx_rcv_count,
    input  wire                    rx_dma_ser_read,
    input  wire [SLOT_W-1:0]       rx_slot_counter,
    // clock check report, asynchronous level
    input  wire                    rx_clock_fail,
    // interrupt and dma event
    output wire                    rx_irq,
    output wire                    rx_irq_pulse,
    output wire                    rx_dma_request
);

    reg  [`RSF_FLAG_W-1:0] flags_q;
    reg  [`RSF_FLAG_W-1:0] flags_d;
    reg  [`RSF_FLAG_W-1:0] ien_q;
    reg  [`RSF_FLAG_W-1:0] set_vec;
    reg  [`RSF_FLAG_W-1:0] clr_vec;
    reg  [`RSF_DATA_W-1:0] rdata_q;
    reg                    ack_q;
    reg                    buf_full_q;
    reg  [SER_W:0]         reads_q;
    reg                    clk_fail_prev_q;
    reg                    coll_q;
    reg                    dma_req_q;
    wire                   clk_fail_s;
    wire                   wr_status;
    wire                   wr_ien;
    wire                   err_sum;
    wire                   overread;
    wire [SER_W:0]         reads_inc;
    wire [SER_W:0]         reads_now;
    wire [`RSF_FLAG_W-1:0] ien_map;

    // status word assembled from flags and live bits
    function [`RSF_DATA_W-1:0] status_word;
        input [`RSF_FLAG_W-1:0] f;
        input                   sum;
        input                   par;
        begin
            status_word = `RSF_ZERO32; // reserved bits read zero
            status_word[`RSF_FLAG_W-1:0] = f & `RSF_FLAG_MASK;
            status_word[`RSF_BIT_SLOT_PAR] = par;
            status_word[`RSF_BIT_ERR_SUM] = sum;
        end
    endfunction

    rsf_sync3 u_clk_fail_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (rx_clock_fail),
        .dout (clk_fail_s)
    );

    // one-cycle answer: waitrequest drops on the cycle after the request;
    // writes land only on the accepting edge, where waitrequest is low
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_status = avs_write & ack_q & (avs_address == `RSF_OFS_STATUS)
                       & avs_byteenable[0];
    assign wr_ien    = avs_write & ack_q & (avs_address == `RSF_OFS_IRQ_ENABLE)
                       & avs_byteenable[0];

    // summary holds no state, derived each cycle
    assign err_sum = flags_q[`RSF_BIT_OVERRUN] | flags_q[`RSF_BIT_EARLY_SYNC]
                   | flags_q[`RSF_BIT_CLK_FAULT] | flags_q[`RSF_BIT_DMA_OVERRD];

    // dma reads beyond configured receivers within the slot; the count
    // saturates so that a wrap can never hide a later overread
    assign reads_inc = (reads_q == {(SER_W+1){1'b1}}) ? reads_q
                     : reads_q + {{SER_W{1'b0}}, 1'b1};
    // a read on the slot boundary is the first of the new slot
    assign reads_now = rx_slot_start ? {{SER_W{1'b0}}, 1'b1} : reads_inc;
    assign overread  = rx_dma_ser_read & (reads_now > {1'b0, rx_rcv_count});

    // set and clear vectors for the sticky flags
    always @*
    begin
        set_vec = `RSF_FLAGS_RESET;
        set_vec[`RSF_BIT_OVERRUN]     = rx_word_moved & buf_full_q & ~rx_buffer_read;
        set_vec[`RSF_BIT_EARLY_SYNC]  = rx_sync_early;
        set_vec[`RSF_BIT_CLK_FAULT]   = clk_fail_s & ~clk_fail_prev_q;
        set_vec[`RSF_BIT_FINAL_SLOT]  = rx_word_moved & rx_is_last_slot;
        set_vec[`RSF_BIT_DATA_READY]  = rx_word_moved;
        set_vec[`RSF_BIT_FRAME_START] = rx_frame_sync;
        set_vec[`RSF_BIT_DMA_OVERRD]  = overread;
        clr_vec = wr_status ? avs_writedata[`RSF_FLAG_W-1:0] : `RSF_FLAGS_RESET;
        flags_d = ((flags_q & ~clr_vec) | set_vec) & `RSF_FLAG_MASK; // set wins
    end

    // flag, enable and bookkeeping registers
    always @(posedge clk)
    begin
        if (rst)
        begin
            flags_q         <= `RSF_FLAGS_RESET;
            ien_q           <= `RSF_IEN_RESET;
            ack_q           <= 1'b0;
            rdata_q         <= `RSF_ZERO32;
            buf_full_q      <= 1'b0;
            reads_q         <= {(SER_W+1){1'b0}};
            clk_fail_prev_q <= 1'b0;
            coll_q          <= 1'b0;
            dma_req_q       <= 1'b0;
        end
        else
        begin
            flags_q         <= flags_d;
            clk_fail_prev_q <= clk_fail_s;
            ack_q           <= (avs_read | avs_write) & ~ack_q;
            coll_q          <= |(set_vec & clr_vec);
            dma_req_q       <= set_vec[`RSF_BIT_DATA_READY];
            if (wr_ien)
                ien_q <= avs_writedata[`RSF_FLAG_W-1:0] & `RSF_IEN_MASK;
            // buffer occupancy tracks unread words for overrun detection
            if (rx_word_moved)
                buf_full_q <= 1'b1;
            else if (rx_buffer_read)
                buf_full_q <= 1'b0;
            // per-slot dma read count restarts at each slot boundary
            if (rx_slot_start)
                reads_q <= rx_dma_ser_read ? {{SER_W{1'b0}}, 1'b1} : {(SER_W+1){1'b0}};
            else if (rx_dma_ser_read)
                reads_q <= reads_inc;
            // read data latched on the request cycle, shown with the ack
            if (avs_read && !ack_q)
            begin
                if (avs_address == `RSF_OFS_STATUS)
                    rdata_q <= status_word(flags_q, err_sum,
                                           rx_slot_counter[0]);
                else if (avs_address == `RSF_OFS_IRQ_ENABLE)
                    rdata_q <= {24'h000000, ien_q};
                else
                    rdata_q <= `RSF_ZERO32; // unmapped reads zero
            end
        end
    end

    assign avs_readdata = rdata_q;

    // enable bit 7 gates frame start flag 6 and enable bit 3 the dma flag 7;
    // the rest map one to one, status bit 3 is no event and never interrupts
    assign ien_map = {ien_q[`RSF_IEN_DMA_OVERRD], ien_q[`RSF_IEN_FRAME_START],
                      ien_q[`RSF_BIT_DATA_READY:`RSF_BIT_FINAL_SLOT], 1'b0,
                      ien_q[`RSF_BIT_CLK_FAULT:`RSF_BIT_OVERRUN]};
    assign rx_irq  = |(flags_q & ien_map);
    assign rx_irq_pulse   = coll_q;
    assign rx_dma_request = dma_req_q;

endmodule

//--- sim/rsf_rx_status_properties.sv
/* assertion checker for the receive status block.
   assumes binding to rsf_rx_status on its single clock clk and reset rst. */
`timescale 1ns/10ps
`include "rsf_consts.vh"
module rsf_rx_status_props #(
    parameter SLOT_W = 10
) (
    // clock and reset
    input wire              clk,
    input wire              rst,
    // bus
    input wire [7:0]        avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    // events and outputs
    input wire              rx_word_moved,
    input wire [SLOT_W-1:0] rx_slot_counter,
    input wire              rx_irq,
    input wire              rx_irq_pulse,
    input wire              rx_dma_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // accepted reads, split by target
    wire rd_ok = avs_read && !avs_waitrequest;
    wire st_rd = rd_ok && avs_address == 8'h80;
    wire un_rd = rd_ok && avs_address != 8'h80 && avs_address != 8'h7C;
    a_dma_follows: assert property (rx_dma_request == $past(rx_word_moved))
        else $error("dma request not one cycle after word move");
    a_wait_once: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered in the second cycle");
    a_reserved_zero: assert property (st_rd |-> avs_readdata[31:9] == 23'h0)
        else $error("reserved status bits not zero");
    a_err_summary: assert property (st_rd |-> avs_readdata[8] ==
        |{avs_readdata[7], avs_readdata[2:0]}) else $error("error summary wrong");
    a_slot_parity: assert property (st_rd |->
        avs_readdata[3] == $past(rx_slot_counter[0])) else $error("slot parity bit wrong");
    a_unmapped_zero: assert property (un_rd |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_pulse_cause: assert property (rx_irq_pulse |-> $past(avs_write))
        else $error("collision pulse without a write");
    a_irq_reset: assert property ($fell(rst) |-> !rx_irq)
        else $error("irq high after reset");
    // main scenarios reached
    c_pulse: cover property (rx_irq_pulse);
    c_irq: cover property (rx_irq);
    c_err: cover property (st_rd && avs_readdata[8]);
endmodule
bind rsf_rx_status rsf_rx_status_props #(.SLOT_W(SLOT_W)) u_props (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_word_moved(rx_word_moved), .rx_slot_counter(rx_slot_counter), .rx_irq(rx_irq),
    .rx_irq_pulse(rx_irq_pulse), .rx_dma_request(rx_dma_request));

//--- sim/rsf_cpu_model.sv
/* cpu side model: avalon-mm master servicing the receive status.
   assumes one clock and a slave that holds waitrequest while busy. */
`timescale 1ns/10ps
module rsf_cpu_model (
    // clock
    input  wire        clk,
    // avalon-mm master
    output reg  [7:0]  avs_address = 8'h00,
    output reg         avs_read = 1'b0,
    output reg         avs_write = 1'b0,
    output reg  [31:0] avs_writedata = 32'h0,
    input  wire [31:0] avs_readdata,
    input  wire        avs_waitrequest
);
    // one transfer, held until waitrequest is seen low at an edge
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released lines must not keep looking valid
        avs_address <= ~a;
        avs_writedata <= ~d;
    end
    endtask
endmodule

//--- sim/tb_audio_receive_status_flags.sv
/* self-checking bench for the receive status block.
   assumes the cpu model as bus master and a 25 ns clock. */
`timescale 1ns/10ps
module tb_audio_receive_status_flags;
    reg         clk = 1'b0, rst = 1'b1, last = 1'b0, cfail = 1'b0, bf = 1'b0, seenp = 1'b0;
    reg  [5:0]  ev = 6'h00; // sync, early, moved, buffer read, slot start, ser read
    reg  [9:0]  slot = 10'h000;
    reg  [7:0]  mf = 8'h00, ien = 8'h00, m;
    reg  [3:0]  rcv = 4'h1; // receivers configured, random per run
    reg  [31:0] got;
    wire [7:0]  adr;
    wire        rd, wr, wq, irq, irqp, dreq;
    wire [31:0] wd, q;
    integer     cnt = 0, fails = 0, comparisons = 0, seed = 53412, i, k;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (irqp === 1'b1) seenp <= 1'b1;
    rsf_rx_status dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(q), .avs_waitrequest(wq),
        .rx_frame_sync(ev[5]), .rx_sync_early(ev[4]), .rx_word_moved(ev[3]),
        .rx_buffer_read(ev[2]), .rx_is_last_slot(last), .rx_slot_start(ev[1]),
        .rx_rcv_count(rcv), .rx_dma_ser_read(ev[0]), .rx_slot_counter(slot),
        .rx_clock_fail(cfail), .rx_irq(irq), .rx_irq_pulse(irqp), .rx_dma_request(dreq));
    rsf_cpu_model cpu (.clk(clk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(q), .avs_waitrequest(wq));
    task give_verdict;
    begin
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task chk_reg(input [31:0] g, input [31:0] e);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    end
    endtask
    task chk_bit(input g, input e);
        chk_reg({31'h0, g}, {31'h0, e});
    endtask
    // one event pulse, mirrored into the flag model
    task pul(input [5:0] v);
        reg l;
    begin
        l = $random(seed);
        @(posedge clk);
        ev <= v;
        last <= l;
        if (v[5]) mf[6] = 1'b1;
        if (v[4]) mf[1] = 1'b1;
        if (v[3] && bf && !v[2]) mf[0] = 1'b1;
        if (v[3]) mf[5:4] = {1'b1, mf[4] | l};
        bf = v[3] | (bf & !v[2]);
        if (v[1]) cnt = 0;
        if (v[0]) cnt = cnt + 1;
        if (v[0] && cnt > rcv) mf[7] = 1'b1;
        @(posedge clk);
        ev <= 6'h00;
        // dma request is registered: it stands in the cycle after the pulse
        @(posedge clk);
        chk_bit(dreq, v[3]);
    end
    endtask
    // status read against the model, irq level alongside
    task rds;
    begin
        @(posedge clk);
        slot <= $random(seed);
        cpu.xfer(1'b0, 8'h80, 32'h0, got);
        chk_reg(got, {23'h0, |{mf[7], mf[2:0]}, mf[7:4], slot[0], mf[2:0]});
        chk_bit(irq, |(mf & {ien[3], ien[7], ien[5:4], 1'b0, ien[2:0]}));
    end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rcv <= {$random(seed)} % 3;
        rds;
        cpu.xfer(1'b1, 8'h7C, 32'hFFFFFFFF, got);
        cpu.xfer(1'b0, 8'h7C, 32'h0, got);
        chk_reg(got, 32'h000000BF);
        ien = 8'hBF;
        cpu.xfer(1'b0, 8'h40, 32'h0, got);
        chk_reg(got, 32'h0);
        for (i = 0; i < 90; i = i + 1)
        begin
            k = {$random(seed)} % 7;
            if (k == 6)
            begin
                cfail <= 1'b1;
                repeat (8) @(posedge clk);
                cfail <= 1'b0;
                mf[2] = 1'b1;
            end
            else
                pul(6'h01 << k);
            rds;
            m = $random(seed);
            if (i % 3 == 0) cpu.xfer(1'b1, 8'h80, {24'h0, m}, got);
            if (i % 3 == 0) mf = mf & ~m;
            if (i % 10 == 0) ien = $random(seed) & 8'hBF;
            if (i % 10 == 0) cpu.xfer(1'b1, 8'h7C, {24'h0, ien}, got);
        end
        // clear landing in the cycle of a new frame sync
        cpu.xfer(1'b1, 8'h80, 32'hFF, got);
        mf = 8'h00;
        chk_bit(seenp, 1'b0);
        // the write lands on its accepting edge, one edge after it is taken,
        // so the pulse starts one edge later to meet it there
        fork
            cpu.xfer(1'b1, 8'h80, 32'h40, got);
            begin
                @(posedge clk);
                pul(6'h20);
            end
        join
        rds;
        chk_bit(seenp, 1'b1);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        {mf, ien, bf, cnt} = 0;
        rds;
        cpu.xfer(1'b0, 8'h7C, 32'h0, got);
        chk_reg(got, 32'h0);
        give_verdict;
    end
    // hang guard, well beyond the fewer than a thousand cycles the tests take
    initial
    begin
        #500000;
        fails = fails + 1;
        give_verdict;
    end
endmodule
